// ### src/tq_defs.svh
// Register map, field positions and timing constants of the trigger qualifier.
// Assumes it is included by bare name from the package and the design files.
`ifndef TQ_DEFS_SVH
`define TQ_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define TQ_ADDR_CTRL    8'h00
`define TQ_ADDR_CFG     8'h04
`define TQ_ADDR_T1      8'h08
`define TQ_ADDR_T2      8'h0C
`define TQ_ADDR_DEV     8'h10
`define TQ_ADDR_HOLD    8'h14
`define TQ_ADDR_LEVEL   8'h18
`define TQ_ADDR_STATUS  8'h1C
`define TQ_ADDR_TRIGCNT 8'h20

// ----------------------------------------------------------------------------
// Command bits of the control register (write only, self clearing)
// ----------------------------------------------------------------------------
`define TQ_CTRL_TOGGLE  0
`define TQ_CTRL_SLOPE   1
`define TQ_CTRL_AUTO_CONFIGURE 2
`define TQ_CTRL_ARM     3
`define TQ_CTRL_RUN     4

// ----------------------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------------------
`define TQ_CFG_TYPE     0
`define TQ_CFG_SRC_LSB  1
`define TQ_CFG_SRC_MSB  4
`define TQ_CFG_NEG      5
`define TQ_CFG_CMP_LSB  6
`define TQ_CFG_CMP_MSB  8
`define TQ_CFG_LP       9
`define TQ_CFG_NR       10
`define TQ_CFG_AC       11
`define TQ_CFG_HF       12
`define TQ_CFG_HOLD_EN  13
`define TQ_REF_COARSE   31
`define TQ_CFG_RESET    32'h0000_0000
`define TQ_LEVEL_RESET  12'h800

// ----------------------------------------------------------------------------
// Times and counts
// ----------------------------------------------------------------------------
`define TQ_CNT_W          34
`define TQ_CLK_NS         34'd40
`define TQ_TICK_NS        34'd2
`define TQ_US_NS          34'd1000
`define TQ_REF_MIN_NS     34'd16
`define TQ_HOLD_MIN_NS    34'd50
`define TQ_DEV_STEP_NS    34'd8
`define TQ_FINE_MAX_NS    34'd1000000
`define TQ_MAX_US         31'h0098_9680
`define TQ_DEV_MAX_STEPS  17'h1_410B
`define TQ_TICKS_PER_CLK  (`TQ_CLK_NS / `TQ_TICK_NS)
`define TQ_US_TICKS       (`TQ_US_NS / `TQ_TICK_NS)
`define TQ_DEV_TICKS      (`TQ_DEV_STEP_NS / `TQ_TICK_NS)
`define TQ_REF_MIN_TICKS  ((`TQ_REF_MIN_NS + `TQ_TICK_NS - 34'd1) / `TQ_TICK_NS)
`define TQ_HOLD_MIN_TICKS ((`TQ_HOLD_MIN_NS + `TQ_TICK_NS - 34'd1) / `TQ_TICK_NS)
`define TQ_FINE_MAX_TICKS (`TQ_FINE_MAX_NS / `TQ_TICK_NS)
`define TQ_MAX_TICKS      (34'(`TQ_MAX_US) * `TQ_US_TICKS)
`define TQ_CNT_MAX        34'h3_FFFF_FFFF

`endif

// ### src/tq_pkg.sv
// Types shared by the trigger qualifier files.
// Assumes tq_defs.svh is on the include path.
`include "tq_defs.svh"
package tq_pkg;

  typedef enum logic [1:0] {
    TQ_SLOPE_RISE = 2'h0,
    TQ_SLOPE_FALL = 2'h1,
    TQ_SLOPE_BOTH = 2'h2
  } tq_slope_t;

  typedef enum logic [2:0] {
    TQ_CMP_GT  = 3'h0,
    TQ_CMP_LT  = 3'h1,
    TQ_CMP_EQ  = 3'h2,
    TQ_CMP_NE  = 3'h3,
    TQ_CMP_IN  = 3'h4,
    TQ_CMP_OUT = 3'h5
  } tq_cmp_t;

  typedef enum logic [2:0] {
    TQ_ST_RUN  = 3'b001,
    TQ_ST_HOLD = 3'b010,
    TQ_ST_STOP = 3'b100
  } tq_state_t;

  typedef struct packed {
    logic        ac_coupling;
    logic        high_freq_coupling;
    logic        lowpass_trigger_filter;
    logic        noise_reduction_filter;
    logic [11:0] level;
  } tq_fe_ctrl_t;

endpackage

// ### src/tq_tick_counter.sv
// Saturating time counter in 2 ns ticks, advanced once per clock.
// Assumes one 25 MHz clock; a clear loads one clock period of ticks.
`timescale 1ns/1ps
`default_nettype none
`include "tq_defs.svh"
module tq_tick_counter (
  input  wire logic                  clk_in,
  input  wire logic                  resetn_in,
  input  wire logic                  clear_in,
  input  wire logic                  run_in,
  output logic [`TQ_CNT_W-1:0]       count_out
);

  logic [`TQ_CNT_W-1:0] count_q;
  logic [`TQ_CNT_W-1:0] count_d;
  wire                  at_top = (count_q > (`TQ_CNT_MAX - `TQ_TICKS_PER_CLK));

  // Saturation keeps an overlong pulse from wrapping into a short one.
  assign count_d = clear_in ? `TQ_TICKS_PER_CLK :
                   !run_in  ? count_q :
                   at_top   ? `TQ_CNT_MAX : count_q + `TQ_TICKS_PER_CLK;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign count_out = count_q;

endmodule
`default_nettype wire

// ### src/tq_trigger.sv
// Trigger decision logic: mode, source, edge and pulse-width qualification.
// Assumes inputs synchronous to clk_in and a one-cycle register strobe bus.
// What this block does
// R1: Auto mode self-triggers without qualifying event.
// R2: Normal mode triggers only on met condition.
// R3: Single shot arms once, stops after trigger.
// R4: Mode key toggles between auto and normal.
// R5: Sources: two channels, eight digital, mains.
// R6: Edge mode fires on selected level crossing.
// R7: Slope key cycles rising, falling, both.
// R8: Auto configure forces edge trigger type.
// R9: Lowpass and noise reduction filters exclusive.
// R10: AC auto limits level to peaks.
// R11: Pulse mode fires on trailing edge.
// R12: Width measured between edges per polarity.
// R13: Six width comparisons are selectable.
// R14: Equal means within reference plus deviation.
// R15: Unequal means outside reference plus deviation.
// R16: In range is between lower and upper.
// R17: Out of range is beyond either bound.
// R18: Reference times span 16 ns to 10 s.
// R19: 2 ns steps to 1 ms, then microseconds.
// R20: Deviation in 8 ns steps to 657.5 us.
// R21: Hold-off blocks triggers, may be disabled.
// R22: Auto self-trigger after configurable timeout.
// R23: Width counter uses 2 ns ticks, saturates.
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "tq_defs.svh"
module tq_trigger #(
  parameter int unsigned AUTO_TIMEOUT_NS = 100000000
) (
  input  wire logic               clk_in,
  input  wire logic               resetn_in,
  input  wire logic [7:0]         addr_in,
  input  wire logic [31:0]        wr_data_in,
  input  wire logic               wr_in,
  input  wire logic               rd_in,
  input  wire logic [1:0]         ch_above_in,
  input  wire logic [7:0]         dig_in,
  input  wire logic               probe_present_in,
  input  wire logic               mains_sync_source_in,
  input  wire logic [11:0]        peak_max_in,
  input  wire logic [11:0]        peak_min_in,
  output logic [31:0]             rd_data_out,
  output logic                    trigger_out,
  output logic                    stopped_out,
  output tq_pkg::tq_fe_ctrl_t     fe_ctrl_out
);

  // --------------------------------------------------------------------------
  // Constants
  // --------------------------------------------------------------------------
  localparam int unsigned AUTO_CYC  = AUTO_TIMEOUT_NS / int'(`TQ_CLK_NS);
  localparam logic [31:0] AUTO_LAST = (AUTO_CYC > 1) ? 32'(AUTO_CYC - 1) : 32'h0000_0000;

  // Turns a reference register into ticks, bounded to the legal span.
  function automatic logic [`TQ_CNT_W-1:0] to_ticks(input logic [31:0] r,
                                                     input logic [`TQ_CNT_W-1:0] lo);
    logic [30:0]           v;
    logic [`TQ_CNT_W-1:0]  t;
    v = (r[30:0] > `TQ_MAX_US) ? `TQ_MAX_US : r[30:0];
    // R19: fine and coarse resolution
    t = r[`TQ_REF_COARSE] ? 34'(v) * `TQ_US_TICKS : 34'(r[30:0]);
    if (!r[`TQ_REF_COARSE] && t > `TQ_FINE_MAX_TICKS) t = `TQ_FINE_MAX_TICKS;
    // R18: bounded reference span
    if (t < lo) t = lo;
    if (t > `TQ_MAX_TICKS) t = `TQ_MAX_TICKS;
    return t;
  endfunction

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic                 mode_normal_q;
  logic                 single_q;
  tq_pkg::tq_slope_t    slope_q;
  logic                 type_pulse_q;
  logic [3:0]           src_q;
  logic                 neg_q;
  tq_pkg::tq_cmp_t      cmp_q;
  logic                 lp_q;
  logic                 nr_q;
  logic                 ac_q;
  logic                 hf_q;
  logic                 hold_en_q;
  logic [31:0]          t1_q;
  logic [31:0]          t2_q;
  logic [16:0]          dev_q;
  logic [31:0]          hold_q;
  logic [11:0]          level_q;
  tq_pkg::tq_state_t    state_q;
  tq_pkg::tq_state_t    state_d;
  logic                 s_q;
  logic [31:0]          auto_cnt_q;
  logic                 trig_q;
  logic [31:0]          trig_cnt_q;
  logic [31:0]          rd_data_q;
  tq_pkg::tq_fe_ctrl_t  fe_q;

  // --------------------------------------------------------------------------
  // Register bus decode
  // --------------------------------------------------------------------------
  wire wr_ctrl    = wr_in && (addr_in == `TQ_ADDR_CTRL);
  wire wr_cfg     = wr_in && (addr_in == `TQ_ADDR_CFG);
  wire do_toggle  = wr_ctrl && wr_data_in[`TQ_CTRL_TOGGLE];
  wire do_slope   = wr_ctrl && wr_data_in[`TQ_CTRL_SLOPE];
  wire do_auto_configure = wr_ctrl && wr_data_in[`TQ_CTRL_AUTO_CONFIGURE];
  wire do_arm     = wr_ctrl && wr_data_in[`TQ_CTRL_ARM];
  wire do_run     = wr_ctrl && wr_data_in[`TQ_CTRL_RUN];
  wire new_lp     = wr_data_in[`TQ_CFG_LP];
  // R9: lowpass wins when both are requested
  wire new_nr     = wr_data_in[`TQ_CFG_NR] && !new_lp;

  // R7: slope advances cyclically
  wire tq_pkg::tq_slope_t slope_next =
    (slope_q == tq_pkg::TQ_SLOPE_RISE) ? tq_pkg::TQ_SLOPE_FALL :
    (slope_q == tq_pkg::TQ_SLOPE_FALL) ? tq_pkg::TQ_SLOPE_BOTH : tq_pkg::TQ_SLOPE_RISE;

  // --------------------------------------------------------------------------
  // Source selection and edges
  // --------------------------------------------------------------------------
  // R5: digital inputs count only with the probe attached
  wire [15:0] src_vec = {5'h00, mains_sync_source_in, dig_in & {8{probe_present_in}},
                         ch_above_in};
  wire        s_now   = src_vec[src_q];
  wire        rise    = s_now && !s_q;
  wire        fall    = !s_now && s_q;
  // R6: selected crossing direction
  wire        edge_hit = (slope_q == tq_pkg::TQ_SLOPE_RISE) ? rise :
                         (slope_q == tq_pkg::TQ_SLOPE_FALL) ? fall : (rise || fall);

  // R12: polarity picks the edges that bound the pulse
  wire        lead     = neg_q ? fall : rise;
  wire        trail    = neg_q ? rise : fall;
  wire        in_pulse = s_now ^ neg_q;

  // --------------------------------------------------------------------------
  // Width measurement and comparison
  // --------------------------------------------------------------------------
  logic [`TQ_CNT_W-1:0] width;
  logic [`TQ_CNT_W-1:0] hold_cnt;

  // R23: width counter on the 2 ns time base
  tq_tick_counter u_width (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .clear_in  (lead),
    .run_in    (in_pulse),
    .count_out (width)
  );

  wire [16:0] dev_steps = (dev_q == 17'h0_0000) ? 17'h0_0001 :
                          (dev_q > `TQ_DEV_MAX_STEPS) ? `TQ_DEV_MAX_STEPS : dev_q;
  // R20: deviation in 8 ns steps
  wire [`TQ_CNT_W-1:0] dev_t  = 34'(dev_steps) * `TQ_DEV_TICKS;
  wire [`TQ_CNT_W-1:0] t1_t   = to_ticks(t1_q, `TQ_REF_MIN_TICKS);
  wire [`TQ_CNT_W-1:0] t2_t   = to_ticks(t2_q, `TQ_REF_MIN_TICKS);
  wire [`TQ_CNT_W-1:0] hold_t = to_ticks(hold_q, `TQ_HOLD_MIN_TICKS);
  wire [`TQ_CNT_W-1:0] eq_lo  = (t1_t > dev_t) ? (t1_t - dev_t) : '0;
  wire [`TQ_CNT_W-1:0] eq_hi  = t1_t + dev_t;
  // R14: tolerance window around the reference
  wire in_tol  = (width >= eq_lo) && (width <= eq_hi);
  // R16: strictly between lower and upper
  wire in_rng  = (width > t1_t) && (width < t2_t);
  // R17: beyond either bound
  wire out_rng = (width > t2_t) || (width < t1_t);

  // R13: six comparisons
  // R15: unequal is outside the tolerance window
  wire width_ok = (cmp_q == tq_pkg::TQ_CMP_GT)  ? (width > t1_t) :
                  (cmp_q == tq_pkg::TQ_CMP_LT)  ? (width < t1_t) :
                  (cmp_q == tq_pkg::TQ_CMP_EQ)  ? in_tol :
                  (cmp_q == tq_pkg::TQ_CMP_NE)  ? !in_tol :
                  (cmp_q == tq_pkg::TQ_CMP_IN)  ? in_rng :
                  (cmp_q == tq_pkg::TQ_CMP_OUT) ? out_rng : 1'b0;

  // R11: pulse trigger only on the trailing edge
  wire cond = type_pulse_q ? (trail && width_ok) : edge_hit;

  // --------------------------------------------------------------------------
  // Trigger sequencing
  // --------------------------------------------------------------------------
  wire running   = (state_q == tq_pkg::TQ_ST_RUN);
  // R2: normal and single fire only on a met condition
  wire cond_fire = running && cond;
  // R1: automatic mode fires by itself
  wire auto_fire = running && !mode_normal_q && !single_q && !cond &&
                   (auto_cnt_q == AUTO_LAST);
  wire fire      = cond_fire || auto_fire;
  // R21: hold-off expiry
  wire hold_done = (hold_cnt >= hold_t);

  tq_tick_counter u_hold (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .clear_in  (fire),
    .run_in    (state_q == tq_pkg::TQ_ST_HOLD),
    .count_out (hold_cnt)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      tq_pkg::TQ_ST_RUN: begin
        // R3: a single shot stops after its trigger
        if (fire && single_q) begin
          state_d = tq_pkg::TQ_ST_STOP;
        end else if (fire && hold_en_q) begin
          state_d = tq_pkg::TQ_ST_HOLD;
        end
      end
      tq_pkg::TQ_ST_HOLD: begin
        if (hold_done) begin
          state_d = tq_pkg::TQ_ST_RUN;
        end
      end
      tq_pkg::TQ_ST_STOP: begin
        state_d = tq_pkg::TQ_ST_STOP;
      end
      default: begin
        state_d = tq_pkg::TQ_ST_RUN;
      end
    endcase
    // Re-arming overrides any state so software never waits on hold-off.
    if (do_arm || do_run) begin
      state_d = tq_pkg::TQ_ST_RUN;
    end
  end

  // R10: peak-to-peak limit only for AC coupling in auto mode
  wire        lvl_limit = ac_q && !mode_normal_q;
  wire [11:0] level_eff = !lvl_limit ? level_q :
                          (level_q > peak_max_in) ? peak_max_in :
                          (level_q < peak_min_in) ? peak_min_in : level_q;

  // --------------------------------------------------------------------------
  // Read multiplexer
  // --------------------------------------------------------------------------
  wire [31:0] cfg_rd = {18'h0_0000, hold_en_q, hf_q, ac_q, nr_q, lp_q, cmp_q, neg_q, src_q,
                        type_pulse_q};
  wire [31:0] st_rd  = {26'h000_0000, (state_q == tq_pkg::TQ_ST_HOLD),
                        (state_q == tq_pkg::TQ_ST_STOP), single_q, slope_q, mode_normal_q};
  wire [31:0] rd_mux = (addr_in == `TQ_ADDR_CFG)     ? cfg_rd :
                       (addr_in == `TQ_ADDR_T1)      ? t1_q :
                       (addr_in == `TQ_ADDR_T2)      ? t2_q :
                       (addr_in == `TQ_ADDR_DEV)     ? {15'h0000, dev_q} :
                       (addr_in == `TQ_ADDR_HOLD)    ? hold_q :
                       (addr_in == `TQ_ADDR_LEVEL)   ? {20'h0_0000, level_q} :
                       (addr_in == `TQ_ADDR_STATUS)  ? st_rd :
                       (addr_in == `TQ_ADDR_TRIGCNT) ? trig_cnt_q : 32'h0000_0000;

  // --------------------------------------------------------------------------
  // Flip-flops
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_normal_q <= 1'b0;
      single_q      <= 1'b0;
      slope_q       <= tq_pkg::TQ_SLOPE_RISE;
      type_pulse_q  <= 1'b0;
      src_q         <= 4'h0;
      neg_q         <= 1'b0;
      cmp_q         <= tq_pkg::TQ_CMP_GT;
      lp_q          <= 1'b0;
      nr_q          <= 1'b0;
      ac_q          <= 1'b0;
      hf_q          <= 1'b0;
      hold_en_q     <= 1'b0;
    end else begin
      // R4: mode key toggles auto and normal
      if (do_toggle) mode_normal_q <= !mode_normal_q;
      if (do_arm) single_q <= 1'b1;
      else if (do_run) single_q <= 1'b0;
      if (do_slope) slope_q <= slope_next;
      if (wr_cfg) begin
        type_pulse_q <= wr_data_in[`TQ_CFG_TYPE];
        src_q        <= wr_data_in[`TQ_CFG_SRC_MSB:`TQ_CFG_SRC_LSB];
        neg_q        <= wr_data_in[`TQ_CFG_NEG];
        cmp_q        <= tq_pkg::tq_cmp_t'(wr_data_in[`TQ_CFG_CMP_MSB:`TQ_CFG_CMP_LSB]);
        lp_q         <= new_lp;
        nr_q         <= new_nr;
        ac_q         <= wr_data_in[`TQ_CFG_AC];
        hf_q         <= wr_data_in[`TQ_CFG_HF];
        hold_en_q    <= wr_data_in[`TQ_CFG_HOLD_EN];
      end
      // R8: auto configure forces edge type
      if (do_auto_configure) type_pulse_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      t1_q    <= 32'h0000_0000;
      t2_q    <= 32'h0000_0000;
      dev_q   <= 17'h0_0000;
      hold_q  <= 32'h0000_0000;
      level_q <= `TQ_LEVEL_RESET;
    end else if (wr_in) begin
      if (addr_in == `TQ_ADDR_T1) t1_q <= wr_data_in;
      if (addr_in == `TQ_ADDR_T2) t2_q <= wr_data_in;
      if (addr_in == `TQ_ADDR_DEV) dev_q <= wr_data_in[16:0];
      if (addr_in == `TQ_ADDR_HOLD) hold_q <= wr_data_in;
      if (addr_in == `TQ_ADDR_LEVEL) level_q <= wr_data_in[11:0];
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q    <= tq_pkg::TQ_ST_RUN;
      s_q        <= 1'b0;
      auto_cnt_q <= 32'h0000_0000;
      trig_q     <= 1'b0;
      trig_cnt_q <= 32'h0000_0000;
      rd_data_q  <= 32'h0000_0000;
      fe_q       <= '0;
    end else begin
      state_q    <= state_d;
      s_q        <= s_now;
      // R22: timeout restarts on every trigger and outside the run state
      auto_cnt_q <= (fire || !running) ? 32'h0000_0000 :
                    (auto_cnt_q == AUTO_LAST) ? auto_cnt_q : auto_cnt_q + 32'h0000_0001;
      trig_q     <= fire;
      trig_cnt_q <= fire ? trig_cnt_q + 32'h0000_0001 : trig_cnt_q;
      rd_data_q  <= rd_in ? rd_mux : 32'h0000_0000;
      fe_q       <= '{ac_q, hf_q, lp_q, nr_q, level_eff};
    end
  end

  assign rd_data_out = rd_data_q;
  assign trigger_out = trig_q;
  assign stopped_out = (state_q == tq_pkg::TQ_ST_STOP);
  assign fe_ctrl_out = fe_q;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  a_single_stops: assert property (fire && single_q && running |=> // R3
    stopped_out ##1 !trigger_out) else $error("single shot did not stop");
  a_stop_quiet: assert property (stopped_out && !do_arm && !do_run |=> !trigger_out) // R3
    else $error("trigger while stopped");
  a_mode_toggle: assert property (do_toggle |=> mode_normal_q != $past(mode_normal_q)) // R4
    else $error("mode did not toggle");
  a_slope_cycle: assert property (do_slope && slope_q == tq_pkg::TQ_SLOPE_FALL |=> // R7
    slope_q == tq_pkg::TQ_SLOPE_BOTH) else $error("slope order wrong");
  a_auto_configure_edge: assert property (do_auto_configure |=> !type_pulse_q) // R8
    else $error("auto configure left pulse type");
  a_filter_excl: assert property (!(fe_ctrl_out.lowpass_trigger_filter && // R9
    fe_ctrl_out.noise_reduction_filter)) else $error("both filters on");
  a_normal_cond: assert property (mode_normal_q && fire |-> cond) // R2
    else $error("normal mode fired without condition");
  a_holdoff_block: assert property (state_q == tq_pkg::TQ_ST_HOLD |=> !trigger_out) // R21
    else $error("trigger during hold-off");
  a_pulse_trail: assert property (type_pulse_q && cond_fire |-> trail) // R11
    else $error("pulse trigger off trailing edge");
  a_level_limit: assert property (lvl_limit && peak_min_in <= peak_max_in |=> // R10
    fe_ctrl_out.level <= $past(peak_max_in)) else $error("level beyond peak");
  a_auto_timeout: assert property (auto_cnt_q == AUTO_LAST && running && !mode_normal_q && // R1
    !single_q |=> trigger_out) else $error("no self trigger at timeout");

endmodule
`default_nettype wire

// ### tb/tb_tq_trigger.sv
// Self-checking bench for the trigger qualifier: keys, sources, edges, widths.
// Assumes the front end model and an auto timeout of 10 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "tq_defs.svh"
module tb_tq_trigger;
  logic                clk_in;
  logic                resetn_in;
  logic [7:0]          addr;
  logic [31:0]         wdata;
  logic                wr_s;
  logic                rd_s;
  logic                rd_d = 1'b0;
  logic                probe;
  logic [1:0]          ch_above;
  logic [7:0]          dig;
  logic                mains;
  logic [11:0]         pk_max;
  logic [11:0]         pk_min;
  logic [31:0]         rdata;
  logic                trig;
  logic                stopped;
  tq_pkg::tq_fe_ctrl_t fe;
  logic [31:0]         exp_q[$];
  int                  err_count;
  int                  checked;
  int                  trig_n = 0;
  int                  i;
  int                  b;
  int                  pe[6] = '{1, 0, 1, 0, 1, 0};

  tq_trigger #(.AUTO_TIMEOUT_NS(400)) tq_trigger_i (
    .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr), .wr_data_in(wdata),
    .wr_in(wr_s), .rd_in(rd_s), .ch_above_in(ch_above), .dig_in(dig),
    .probe_present_in(probe), .mains_sync_source_in(mains), .peak_max_in(pk_max),
    .peak_min_in(pk_min), .rd_data_out(rdata), .trigger_out(trig),
    .stopped_out(stopped), .fe_ctrl_out(fe));

  tq_fe_model tq_fe_model_i (
    .clk_in(clk_in), .ch_above_out(ch_above), .dig_out(dig), .mains_out(mains),
    .peak_max_out(pk_max), .peak_min_out(pk_min));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] e);
    checked++;
    if (seen !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, e, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_in);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_in);
    addr <= a;
    rd_s <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_in);
    rd_s <= 1'b0;
  endtask

  task automatic shot(input int src, input int len, input int e);
    int b0;
    repeat (4) @(negedge clk_in);
    b0 = trig_n;
    tq_fe_model_i.pulse(src, len);
    repeat (30) @(negedge clk_in);
    check("trigger count", 32'(trig_n - b0), 32'(e));
  endtask

  // Read data stand only in the cycle after the strobe, so look there alone.
  always @(posedge clk_in) begin
    if (rd_d) begin
      check("read data", rdata, exp_q.pop_front());
    end
    rd_d <= rd_s;
    if (trig === 1'b1) trig_n <= trig_n + 1;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(32'h36d9_fbee));
    resetn_in = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr_s = 1'b0;
    rd_s = 1'b0;
    probe = 1'b1;
    err_count = 0;
    checked = 0;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd(`TQ_ADDR_STATUS, 32'h0000_0000);
    rd(`TQ_ADDR_CFG, 32'h0000_0000);
    rd(8'h24, 32'h0000_0000);
    for (i = 1; i <= 3; i++) begin
      wr(`TQ_ADDR_CTRL, 32'h0000_0002);
      rd(`TQ_ADDR_STATUS, 32'((i % 3) << 1));
    end
    wr(`TQ_ADDR_CTRL, 32'h0000_0001);
    rd(`TQ_ADDR_STATUS, 32'h0000_0001);
    for (i = 0; i < 4; i++) begin
      b = int'($urandom & 32'h0000_0FFF);
      wr(`TQ_ADDR_LEVEL, 32'(b));
      rd(`TQ_ADDR_LEVEL, 32'(b));
    end
    $display("test keys done");
    for (i = 0; i < 11; i++) begin
      wr(`TQ_ADDR_CFG, 32'(i << 1));
      shot(i, 3, 1);
    end
    // A detached probe must leave its lines dead as trigger sources.
    wr(`TQ_ADDR_CFG, 32'h0000_0004);
    probe <= 1'b0;
    shot(2, 3, 0);
    wr(`TQ_ADDR_CFG, 32'h0000_0000);
    probe <= 1'b1;
    wr(`TQ_ADDR_CTRL, 32'h0000_0002);
    shot(0, 3, 1);
    wr(`TQ_ADDR_CTRL, 32'h0000_0002);
    shot(0, 3, 2);
    // Hold-off of 100 cycles swallows the falling edge of the same pulse.
    wr(`TQ_ADDR_HOLD, 32'h0000_07D0);
    wr(`TQ_ADDR_CFG, 32'h0000_2000);
    shot(0, 3, 1);
    rd(`TQ_ADDR_STATUS, 32'h0000_0025);
    wr(`TQ_ADDR_CTRL, 32'h0000_0012);
    $display("test edges done");
    wr(`TQ_ADDR_T1, 32'h0000_0034);
    wr(`TQ_ADDR_T2, 32'h0000_0046);
    wr(`TQ_ADDR_DEV, 32'h0000_0002);
    for (i = 0; i < 6; i++) begin
      wr(`TQ_ADDR_CFG, 32'(i << 6) | 32'h0000_0001);
      shot(0, 3, pe[i]);
    end
    wr(`TQ_ADDR_T2, 32'h0000_003C);
    wr(`TQ_ADDR_CFG, 32'h0000_0101);
    shot(0, 3, 0);
    wr(`TQ_ADDR_CTRL, 32'h0000_0004);
    rd(`TQ_ADDR_CFG, 32'h0000_0100);
    // Negative pulses: the first low span is short, the second spans a whole shot.
    wr(`TQ_ADDR_T1, 32'h0000_0100);
    wr(`TQ_ADDR_CFG, 32'h0000_0021);
    shot(0, 3, 0);
    shot(0, 3, 1);
    wr(`TQ_ADDR_CFG, 32'h0000_0001);
    shot(0, 3, 0);
    $display("test widths done");
    wr(`TQ_ADDR_CFG, 32'h0000_1600);
    rd(`TQ_ADDR_CFG, 32'h0000_1200);
    check("filters", 32'(fe[15:12]), 32'h0000_0006);
    wr(`TQ_ADDR_LEVEL, 32'h0000_0F00);
    wr(`TQ_ADDR_CFG, 32'h0000_0800);
    repeat (2) @(negedge clk_in);
    check("level normal", 32'(fe.level), 32'h0000_0F00);
    check("coupling", 32'(fe[15:12]), 32'h0000_0008);
    wr(`TQ_ADDR_CTRL, 32'h0000_0001);
    repeat (2) @(negedge clk_in);
    check("level auto", 32'(fe.level), 32'h0000_0900);
    b = trig_n;
    repeat (30) @(negedge clk_in);
    check("self triggers", 32'(trig_n - b), 32'h0000_0003);
    wr(`TQ_ADDR_CTRL, 32'h0000_0008);
    shot(0, 3, 1);
    check("stopped", 32'(stopped), 32'h0000_0001);
    rd(`TQ_ADDR_STATUS, 32'h0000_0018);
    shot(0, 3, 0);
    $display("test modes done");
    print_verdict();
  end
endmodule
`default_nettype wire

// ### tb/tq_fe_model.sv
// Front end stand-in: channel comparators, probe lines, pulsed mains line, peaks.
// Assumes the bench calls pulse() from its own process, one pulse at a time.
`timescale 1ns/1ps
`default_nettype none
module tq_fe_model (
  input  wire logic   clk_in,
  output logic [1:0]  ch_above_out,
  output logic [7:0]  dig_out,
  output logic        mains_out,
  output logic [11:0] peak_max_out,
  output logic [11:0] peak_min_out
);
  // Every line rests low between pulses, as a comparator under its level does.
  initial begin
    ch_above_out = 2'h0;
    dig_out = 8'h00;
    mains_out = 1'b0;
    peak_max_out = 12'h900;
    peak_min_out = 12'h200;
  end

  // Source 0..1 channels, 2..9 probe lines, 10 mains; high for len cycles.
  task automatic pulse(input int src, input int len);
    for (int i = 0; i <= len; i++) begin
      @(posedge clk_in);
      if (src < 2) ch_above_out[src] <= (i < len);
      else if (src < 10) dig_out[src - 2] <= (i < len);
      else mains_out <= (i < len);
    end
  endtask
endmodule
`default_nettype wire
